/* src/p2s_pkg.sv */
// Purpose: Shared constants for the parallel-to-serial character converter.
// Assumes: 40 MHz system clock; bit clock arrives as a synchronous input.
// Notes:   Behaviour
// Behaviour
// - Storage captures mark on one-side prime, space on zero-side prime.
// - Storage load pulse coincides with the bit counter reset pulse.
// - Build option sends true or complemented storage outputs.
// - Reset-state bit merges into serial output only in start-stop.
// - Counter takes up to sixteen clocks; counts beyond eight send mark.
// - Code width five to eight; five forces 8,7,1, six forces 8,7.
// - A forced level is sent as mark when sampled.
// - Each character-available triggers a two millisecond auxiliary pulse.
// - During header sequence the length selector is ignored; strap rules.
// - Header strap decodes a counter value, e.g. nine, as terminal.
// - Clock after terminal count resets counter to 0000 or 0001.
// - Reset pulse loads offered character and sets reader step flop.
// - Outside header, length resets on clock 6-16 (SS) or 5-15 (sync).
// - Reader step flop clears when counter reaches two.
// - Step pulse lasts one or two bit clocks, once per character.
// - Serial output retimed by flop set up half a bit earlier.
// - Counter advances on the opposite bit clock edge to retiming.
// - Abnormal-traffic indicator follows the abnormal-traffic input.
// - Storage positions are sampled in turn, one bit clock each.
// - Synchronous format never samples the start-element position.

package p2s_pkg;

    // ------------------------------------------------------------
    // Widths and counter values
    // ------------------------------------------------------------
    localparam int          CNT_W          = 4;
    localparam int          LEVELS         = 8;
    localparam logic [3:0]  CNT_SS_RESET   = 4'h0;
    localparam logic [3:0]  CNT_SYNC_RESET = 4'h1;
    localparam logic [3:0]  CNT_START      = 4'h0;
    localparam logic [3:0]  CNT_STEP_CLEAR = 4'h2;
    localparam logic [3:0]  CNT_LAST_LEVEL = 4'h8;
    localparam logic [3:0]  TC_MIN         = 4'h5;
    localparam logic [3:0]  HDR_TC0        = 4'h6;
    localparam logic [3:0]  HDR_TC1        = 4'h7;
    localparam logic [3:0]  HDR_TC2        = 4'h8;
    localparam logic [3:0]  HDR_TC3        = 4'h9;

    // ------------------------------------------------------------
    // Code width and forced level masks (bit n = level n+1)
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CW_FIVE  = 2'h0,
        CW_SIX   = 2'h1,
        CW_SEVEN = 2'h2,
        CW_EIGHT = 2'h3
    } code_width_type;

    localparam logic [7:0]  FORCE_FIVE     = 8'hC1;
    localparam logic [7:0]  FORCE_SIX      = 8'hC0;
    localparam logic [7:0]  FORCE_SEVEN    = 8'h80;
    localparam logic [7:0]  FORCE_EIGHT    = 8'h00;

    // ------------------------------------------------------------
    // Register map (APB, byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_STATUS    = 8'h04;
    localparam int          CTRL_FMT_BIT   = 0;
    localparam int          CTRL_CW_LSB    = 1;
    localparam int          CTRL_LEN_LSB   = 4;
    localparam logic [7:0]  CTRL_RESET     = 8'hA7;
    localparam int          ST_CNT_LSB     = 0;
    localparam int          ST_STEP_BIT    = 4;
    localparam int          ST_ABN_BIT     = 5;
    localparam int          ST_AUX_BIT     = 6;
    localparam int          ST_AVAIL_BIT   = 7;
    localparam int          ST_CHAR_LSB    = 8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_HZ         = 40_000_000;
    localparam int          AUX_PULSE_MS   = 2;
    localparam int          AUX_CYCLES     = CLK_HZ / 1000 * AUX_PULSE_MS;

endpackage

/* src/char_store.sv */
// Purpose: Storage flip-flops holding the character being serialised.
// Assumes: Load pulse is one clock wide.
// Notes:   Upstream keeps data stable across the load pulse.
`timescale 1ns/1ps

module char_store #(
    parameter int LEVELS = 8
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              srst_i,
    // Load side
    input  wire logic              load_i,
    input  wire logic [LEVELS-1:0] one_prime_i,
    input  wire logic              avail_i,
    // Stored character
    output logic      [LEVELS-1:0] stored_o,
    output logic                   avail_o
);

    logic [LEVELS-1:0] stored_q;
    logic              avail_q;

    // Zero-side prime is the complement; a clear prime stores a space
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            stored_q <= '0;
        end else if (load_i) begin
            stored_q <= one_prime_i & ~(~one_prime_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            avail_q <= 1'b0;
        end else if (load_i) begin
            avail_q <= avail_i;
        end
    end

    assign stored_o = stored_q;
    assign avail_o  = avail_q;

endmodule

/* src/pulse_timer.sv */
// Purpose: Fixed-width pulse generator started by a rising trigger.
// Assumes: Trigger is synchronous to clk_i.
// Notes:   A new rising edge restarts the full width.
`timescale 1ns/1ps

module pulse_timer #(
    parameter int CYCLES = 80000
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic srst_i,
    // Trigger and pulse
    input  wire logic trig_i,
    output logic      pulse_o
);

    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] FULL = W'(CYCLES);
    localparam logic [W-1:0] ONE  = W'(1);

    logic         trig_q;
    logic [W-1:0] cnt_q;
    logic         pulse_q;
    logic         rise;

    assign rise = trig_i & ~trig_q;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= trig_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cnt_q <= '0;
        end else if (rise) begin
            cnt_q <= FULL;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - ONE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= rise | (cnt_q > ONE);
        end
    end

    assign pulse_o = pulse_q;

endmodule

/* src/p2s_converter.sv */
// Purpose: Parallel-to-serial character converter with APB control.
// Assumes: bit_clk_i and all pins synchronous to clk_i; bit clock at most
//          a quarter of clk_i.
// Notes:   Counter steps on bit clock fall, output flop samples on rise.
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps

module p2s_converter #(
    parameter int  AUX_CYCLES   = p2s_pkg::AUX_CYCLES,
    parameter bit  INVERT_STORE = 1'b0
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Upstream character side
    input  wire logic [7:0]  char_data_i,
    input  wire logic        char_avail_i,
    input  wire logic        header_sequence_i,
    input  wire logic [1:0]  header_count_strap_i,
    // Bit clock and serial output
    input  wire logic        bit_clk_i,
    output logic             serial_o,
    output logic             reader_step_o,
    // Indications
    output logic             aux_char_avail_o,
    input  wire logic        abnormal_traffic_i,
    output logic             abnormal_ind_o
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] force_mask(
        input p2s_pkg::code_width_type cw
    );
        unique case (cw)
            p2s_pkg::CW_FIVE:  force_mask = p2s_pkg::FORCE_FIVE;
            p2s_pkg::CW_SIX:   force_mask = p2s_pkg::FORCE_SIX;
            p2s_pkg::CW_SEVEN: force_mask = p2s_pkg::FORCE_SEVEN;
            p2s_pkg::CW_EIGHT: force_mask = p2s_pkg::FORCE_EIGHT;
        endcase
    endfunction

    function automatic logic [3:0] header_tc(input logic [1:0] sel);
        unique case (sel)
            2'h0:    header_tc = p2s_pkg::HDR_TC0;
            2'h1:    header_tc = p2s_pkg::HDR_TC1;
            2'h2:    header_tc = p2s_pkg::HDR_TC2;
            default: header_tc = p2s_pkg::HDR_TC3;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [7:0]  ctrl_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic        setup;
    logic        wr_ctrl;
    logic        mapped;
    logic [31:0] status;

    logic        fmt_ss;
    p2s_pkg::code_width_type cw;
    logic [3:0]  len_sel;

    logic [3:0]  cnt_q;
    logic        step_q;
    logic        abn_q;
    logic [7:0]  stored;
    logic        stored_avail;

    assign setup   = psel_i & ~penable_i;
    assign mapped  = (paddr_i == p2s_pkg::ADDR_CTRL) |
                     (paddr_i == p2s_pkg::ADDR_STATUS);
    assign wr_ctrl = psel_i & penable_i & pwrite_i &
                     (paddr_i == p2s_pkg::ADDR_CTRL);

    assign fmt_ss  = ctrl_q[p2s_pkg::CTRL_FMT_BIT];
    assign cw      = p2s_pkg::code_width_type'(
                     ctrl_q[p2s_pkg::CTRL_CW_LSB +: 2]);
    assign len_sel = ctrl_q[p2s_pkg::CTRL_LEN_LSB +: 4];

    always_comb begin
        status = '0;
        status[p2s_pkg::ST_CNT_LSB +: 4]  = cnt_q;
        status[p2s_pkg::ST_STEP_BIT]      = step_q;
        status[p2s_pkg::ST_ABN_BIT]       = abn_q;
        status[p2s_pkg::ST_AUX_BIT]       = aux_char_avail_o;
        status[p2s_pkg::ST_AVAIL_BIT]     = stored_avail;
        status[p2s_pkg::ST_CHAR_LSB +: 8] = stored;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl_q <= p2s_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= pwdata_i[7:0];
        end
    end

    // Read data is captured in the setup cycle so it leaves a flop
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            pslverr_q <= ~mapped;
            if (paddr_i == p2s_pkg::ADDR_CTRL) begin
                prdata_q <= {24'h000000, ctrl_q};
            end else if (paddr_i == p2s_pkg::ADDR_STATUS) begin
                prdata_q <= status;
            end else begin
                prdata_q <= '0;
            end
        end
    end

    assign prdata_o  = prdata_q;
    assign pready_o  = 1'b1;
    assign pslverr_o = pslverr_q & psel_i & penable_i;

    // ------------------------------------------------------------
    // Bit clock edges
    // ------------------------------------------------------------
    logic bclk_q;
    logic bit_rise;
    logic bit_fall;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            bclk_q <= 1'b0;
        end else begin
            bclk_q <= bit_clk_i;
        end
    end

    assign bit_rise = bit_clk_i & ~bclk_q;
    assign bit_fall = ~bit_clk_i & bclk_q;

    // ------------------------------------------------------------
    // Terminal count and reset pulse
    // ------------------------------------------------------------
    logic [3:0] user_tc;
    logic [3:0] term_tc;
    logic [3:0] reset_val;
    logic       load;

    // Selector floor keeps at least the sixth (SS) / fifth (sync) clock
    assign user_tc   = (len_sel < p2s_pkg::TC_MIN) ? p2s_pkg::TC_MIN
                                                    : len_sel;
    assign term_tc   = header_sequence_i ? header_tc(header_count_strap_i)
                                         : user_tc;
    assign reset_val = fmt_ss ? p2s_pkg::CNT_SS_RESET
                              : p2s_pkg::CNT_SYNC_RESET;
    // One pulse both restarts the counter and loads storage;
    // >= recovers if the length shrinks mid-character
    assign load      = bit_fall & (cnt_q >= term_tc);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cnt_q <= p2s_pkg::CNT_START;
        end else if (load) begin
            cnt_q <= reset_val;
        end else if (bit_fall) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    char_store #(
        .LEVELS      (p2s_pkg::LEVELS)
    ) u_store (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .load_i      (load),
        .one_prime_i (char_data_i),
        .avail_i     (char_avail_i),
        .stored_o    (stored),
        .avail_o     (stored_avail)
    );

    // ------------------------------------------------------------
    // Reader step
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            step_q <= 1'b0;
        end else if (load) begin
            step_q <= 1'b1;
        end else if (bit_fall && cnt_q + 4'h1 == p2s_pkg::CNT_STEP_CLEAR) begin
            step_q <= 1'b0;
        end
    end

    assign reader_step_o = step_q;

    // ------------------------------------------------------------
    // Serialiser
    // ------------------------------------------------------------
    logic [7:0] level_out;
    logic [7:0] forced;
    logic [2:0] idx;
    logic       serial_d;
    logic       serial_q;

    assign forced    = force_mask(cw);
    assign level_out = (INVERT_STORE ? ~stored : stored) | forced;
    assign idx       = 3'(cnt_q - 4'h1);

    always_comb begin
        if (cnt_q == p2s_pkg::CNT_START) begin
            // Start element only exists in start-stop; sync idles mark
            serial_d = ~fmt_ss;
        end else if (cnt_q <= p2s_pkg::CNT_LAST_LEVEL) begin
            serial_d = level_out[idx];
        end else begin
            serial_d = 1'b1;
        end
    end

    // Counter settles on the fall, so data waits half a bit here
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            serial_q <= 1'b1;
        end else if (bit_rise) begin
            serial_q <= serial_d;
        end
    end

    assign serial_o = serial_q;

    // ------------------------------------------------------------
    // Indications
    // ------------------------------------------------------------
    pulse_timer #(
        .CYCLES  (AUX_CYCLES)
    ) u_aux (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .trig_i  (char_avail_i),
        .pulse_o (aux_char_avail_o)
    );

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            abn_q <= 1'b0;
        end else begin
            abn_q <= abnormal_traffic_i;
        end
    end

    assign abnormal_ind_o = abn_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    property p_load_captures;
        load |=> stored == $past(char_data_i);
    endproperty
    a_load_captures: assert property (p_load_captures)
        else $error("stored character differs from offered one");

    property p_restart;
        load |=> cnt_q == (fmt_ss ? 4'h0 : 4'h1) && step_q;
    endproperty
    a_restart: assert property (p_restart)
        else $error("counter restart or step set wrong after load");

    property p_level_sample;
        bit_rise && cnt_q >= 4'h1 && cnt_q <= 4'h8 && !forced[idx]
        |=> serial_q == $past(INVERT_STORE ? ~stored[idx] : stored[idx]);
    endproperty
    a_level_sample: assert property (p_level_sample)
        else $error("sampled level does not match storage");

    property p_start_space;
        bit_rise && cnt_q == 4'h0 |=> serial_q == !$past(fmt_ss);
    endproperty
    a_start_space: assert property (p_start_space)
        else $error("start element wrong for format");

    property p_stop_mark;
        bit_rise && cnt_q > 4'h8 |=> serial_q;
    endproperty
    a_stop_mark: assert property (p_stop_mark)
        else $error("count beyond eight did not send mark");

    property p_forced_mark;
        bit_rise && cw == p2s_pkg::CW_FIVE && cnt_q == 4'h1 |=> serial_q;
    endproperty
    a_forced_mark: assert property (p_forced_mark)
        else $error("forced level one not sent as mark");

    property p_header_nine;
        bit_fall && header_sequence_i && header_count_strap_i == 2'h3 &&
        cnt_q == 4'h9 |-> load;
    endproperty
    a_header_nine: assert property (p_header_nine)
        else $error("header count nine did not end character");

    property p_user_len;
        bit_fall && !header_sequence_i && cnt_q < 4'h5 |-> !load;
    endproperty
    a_user_len: assert property (p_user_len)
        else $error("character ended before the shortest length");

    property p_step_clear;
        cnt_q == 4'h2 |-> !step_q;
    endproperty
    a_step_clear: assert property (p_step_clear)
        else $error("reader step still set at count two");

    property p_count_edge;
        !bit_fall |=> $stable(cnt_q);
    endproperty
    a_count_edge: assert property (p_count_edge)
        else $error("counter moved off the falling bit edge");

    property p_abn;
        abnormal_traffic_i |=> abnormal_ind_o ##0 1 or !abnormal_ind_o;
    endproperty

    property p_abn_follow;
        1'b1 |=> abnormal_ind_o == $past(abnormal_traffic_i);
    endproperty
    a_abn_follow: assert property (p_abn_follow)
        else $error("indicator does not follow abnormal input");

    property p_aux_width;
        $rose(char_avail_i) |=> aux_char_avail_o [*8];
    endproperty
    a_aux_width: assert property (p_aux_width)
        else $error("auxiliary pulse did not start");

    property p_sync_no_start;
        !fmt_ss && cnt_q != 4'h0 |=> cnt_q != 4'h0 || $past(cnt_q) == 4'hF;
    endproperty
    a_sync_no_start: assert property (p_sync_no_start)
        else $error("synchronous format reached start position");

    c_load_ss:   cover property (load && fmt_ss);
    c_load_sync: cover property (load && !fmt_ss);
    c_header:    cover property (load && header_sequence_i);
    c_aux:       cover property ($rose(aux_char_avail_o));

endmodule

/* verification/char_source.sv */
// Purpose: Upstream character source feeding the converter.
// Assumes: One new character is offered after each reader step.
// Notes:   Data and available only move well after the load pulse.
`timescale 1ns/1ps

module char_source (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    // Converter side
    input  wire logic       reader_step_i,
    output logic      [7:0] char_data_o,
    output logic            char_avail_o
);
    logic       step_q;
    logic [2:0] wait_q;
    logic [1:0] idx_q;

    function automatic logic [7:0] pick(input logic [1:0] i);
        case (i)
            2'h0:    return 8'h5A;
            2'h1:    return 8'hA5;
            2'h2:    return 8'h3C;
            default: return 8'h96;
        endcase
    endfunction

    // Holding off a few clocks keeps the load edge clean
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            step_q       <= 1'b0;
            wait_q       <= 3'h0;
            idx_q        <= 2'h0;
            char_data_o  <= pick(2'h0);
            char_avail_o <= 1'b1;
        end else begin
            step_q <= reader_step_i;
            if (reader_step_i && !step_q) begin
                wait_q       <= 3'h4;
                char_avail_o <= 1'b0;
            end else if (wait_q != 3'h0) begin
                wait_q <= wait_q - 3'h1;
                if (wait_q == 3'h1) begin
                    idx_q        <= idx_q + 2'h1;
                    char_data_o  <= pick(idx_q + 2'h1);
                    char_avail_o <= 1'b1;
                end
            end
        end
    end
endmodule

/* verification/p2s_converter_test.sv */
// Purpose: Self-checking bench for the character converter.
// Assumes: Bit clock phases of four system clocks each.
// Notes:   Each frame is judged on the second step after a reconfigure.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin \
    num_errors++; \
    $display("wrong value %s expected %0h seen %0h", what, exp, got); end end

module p2s_converter_test;
    logic        clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic        pready_o, pslverr_o, serial_o, reader_step_o;
    logic [7:0]  char_data_i;
    logic        char_avail_i, aux_char_avail_o, abnormal_ind_o;
    logic        header_sequence_i = 1'b0;
    logic [1:0]  header_count_strap_i = 2'h0;
    logic        bit_clk_i = 1'b0;
    logic [1:0]  bdiv = 2'h0;
    logic        abnormal_traffic_i = 1'b0;
    int          num_errors = 0;
    int          checks = 0;

    p2s_converter #(.AUX_CYCLES(20), .INVERT_STORE(1'b0)) u_p2s_converter (
        .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .char_data_i(char_data_i),
        .char_avail_i(char_avail_i), .header_sequence_i(header_sequence_i),
        .header_count_strap_i(header_count_strap_i), .bit_clk_i(bit_clk_i),
        .serial_o(serial_o), .reader_step_o(reader_step_o),
        .aux_char_avail_o(aux_char_avail_o),
        .abnormal_traffic_i(abnormal_traffic_i),
        .abnormal_ind_o(abnormal_ind_o));

    char_source u_char_source (.clk_i(clk_i), .srst_i(srst_i),
        .reader_step_i(reader_step_o), .char_data_o(char_data_i),
        .char_avail_o(char_avail_i));

    always #12.5 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        bdiv <= bdiv + 2'h1;
        if (bdiv == 2'h3) begin
            bit_clk_i <= ~bit_clk_i;
        end
    end

    task automatic final_report;
        if (num_errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= wr;
        paddr_i <= a; pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (n > 50) begin num_errors++; final_report(); end
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0; penable_i <= 1'b0;
    endtask

    task automatic wait_step(input logic v);
        int n;
        n = 0;
        while (reader_step_o !== v) begin
            @(posedge clk_i); #1; n++;
            if (n > 400) begin num_errors++; final_report(); end
        end
    endtask

    function automatic logic exp_bit(input int k, input logic [7:0] v);
        if (k == 0) return 1'b0;
        if (k <= 8) return v[k-1];
        return 1'b1;
    endfunction

    task automatic s_regs;
        logic [31:0] rd;
        logic        err;
        apb(1'b0, p2s_pkg::ADDR_CTRL, 32'h0, rd, err);
        `CHK("ctrl reset", 32'h000000A7, rd)
        apb(1'b1, p2s_pkg::ADDR_STATUS, 32'hFFFFFFFF, rd, err);
        `CHK("status write err", 1'b0, err)
        apb(1'b0, 8'h10, 32'h0, rd, err);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
    endtask

    task automatic run_frame(input logic [7:0] ctrl, input logic hdr,
                             input logic [1:0] strap, input int term);
        logic [31:0] rd;
        logic        err, ss, bc_prev;
        logic [7:0]  ch, frc;
        int          n, k, width, pend;
        apb(1'b1, p2s_pkg::ADDR_CTRL, {24'h0, ctrl}, rd, err);
        header_sequence_i <= hdr;
        header_count_strap_i <= strap;
        @(posedge clk_i); #1;
        wait_step(1'b0); wait_step(1'b1); wait_step(1'b0); wait_step(1'b1);
        ss = ctrl[0];
        ch = char_data_i;
        frc = ctrl[2:1] == 2'h0 ? p2s_pkg::FORCE_FIVE :
              ctrl[2:1] == 2'h1 ? p2s_pkg::FORCE_SIX :
              ctrl[2:1] == 2'h2 ? p2s_pkg::FORCE_SEVEN : p2s_pkg::FORCE_EIGHT;
        k = ss ? 0 : 1;
        n = 0; width = 0; pend = 0; bc_prev = bit_clk_i;
        while (n < 400) begin
            @(posedge clk_i); #1; n++;
            if (width == 0 && reader_step_o === 1'b0) width = n;
            if (width != 0 && reader_step_o === 1'b1) break;
            if (pend > 0) begin
                pend--;
                if (pend == 0) begin
                    `CHK("serial bit", exp_bit(k, ch | frc), serial_o)
                    k++;
                end
            end
            if (bit_clk_i && !bc_prev) pend = 2;
            bc_prev = bit_clk_i;
        end
        `CHK("bit count", term + 1, k)
        `CHK("step width", ss ? 16 : 8, width)
        `CHK("char interval", 8 * (ss ? term + 1 : term), n)
    endtask

    task automatic s_aux;
        int n;
        n = 0;
        while (aux_char_avail_o !== 1'b1 && n < 400) begin
            @(posedge clk_i); #1; n++;
        end
        n = 0;
        while (aux_char_avail_o === 1'b1 && n < 400) begin
            @(posedge clk_i); #1; n++;
        end
        `CHK("aux width", 20, n)
    endtask

    task automatic s_abn;
        @(posedge clk_i);
        abnormal_traffic_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1 `CHK("abnormal on", 1'b1, abnormal_ind_o)
        @(posedge clk_i);
        abnormal_traffic_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1 `CHK("abnormal off", 1'b0, abnormal_ind_o)
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        s_regs();
        run_frame(8'hA7, 1'b0, 2'h0, 10);
        run_frame(8'h61, 1'b0, 2'h0, 6);
        run_frame(8'h52, 1'b0, 2'h0, 5);
        run_frame(8'hF4, 1'b0, 2'h0, 15);
        run_frame(8'hF5, 1'b1, 2'h3, 9);
        run_frame(8'h21, 1'b1, 2'h0, 6);
        s_aux();
        s_abn();
        final_report();
    end
endmodule
